// ### common/fpp_pkg.sv
// Purpose: shared constants and types of the flash program and protect block
// Assumes: 8-bit APB address, 32-bit data, one aligned word per register
// Notes: option byte layout and sector 0 size table are fixed here
`default_nettype none
package fpp_pkg;
   // ****************************************************
   // register map
   // ****************************************************
   localparam logic [7:0] OFF_CSR = 8'h00;
   localparam logic [7:0] OFF_ADDR = 8'h04;
   localparam logic [7:0] OFF_DATA = 8'h08;
   localparam logic [7:0] OFF_OPT = 8'h0c;
   localparam logic [7:0] OFF_STAT = 8'h10;
   localparam logic [7:0] KEY_FIRST = 8'h56;
   localparam logic [7:0] KEY_SECOND = 8'hae;
   localparam logic [2:0] CSR_RESET = 3'h0;
   localparam int CSR_OPT = 2;
   localparam int CSR_LAT = 1;
   localparam int CSR_PGM = 0;
   localparam int ADDR_ERASE = 16;
   localparam logic [7:0] OPT_RESET = 8'h00;
   localparam int OPT_RD = 0;
   localparam int OPT_WE = 1;
   localparam int OPT_SZ = 2;
   // ****************************************************
   // memory layout
   // ****************************************************
   localparam int ROW_BYTES = 32;
   localparam int IDX_W = 5;
   localparam logic [15:0] FLASH_BASE = 16'hf000;
   localparam logic [15:0] EE_BASE = 16'h1000;
   localparam logic [15:0] EE_END = 16'h107f;
   localparam logic [3:0][15:0] SEC0_BASE = {16'hf400, 16'hf800, 16'hfc00, 16'hfe00};
   localparam logic [3:0] ENTRY_EDGES = 4'h4;
   // ****************************************************
   // types
   // ****************************************************
   typedef enum logic [1:0] {MD_SELF, MD_SOCKET, MD_SERIAL} fpp_mode_t;
   typedef enum logic [1:0] {LK_LOCKED, LK_HALF, LK_OPEN} fpp_lock_t;
   typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT_ALL, SQ_WAIT} fpp_seq_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } fpp_apb_req_t;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } fpp_apb_rsp_t;
   typedef struct packed {
      logic valid;
      logic erase;
      logic erase_all;
      logic opt_row;
      logic [15:0] addr;
      logic [ROW_BYTES-1:0] mask;
      logic [ROW_BYTES-1:0][7:0] data;
   } fpp_flash_req_t;
endpackage
`default_nettype wire

// ### rtl/fpp_link_entry.sv
// Purpose: serial programming entry detect on the tool pins
// Assumes: all pins are asynchronous to pclk
// Notes: session lasts until the next presetn
`default_nettype none
`timescale 1ns/1ns
module fpp_link_entry import fpp_pkg::*; (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // tool pins
   input wire logic board_serial_clock,
   input wire logic board_serial_data,
   input wire logic reset_pin_n,
   input wire logic socket_pin,
   // status
   output logic session_ff,
   output logic attached_ff,
   output logic socket_ff
);
   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic clk_prev;
      logic rst_prev;
      logic [3:0] cnt;
      logic session;
      logic attached;
   } fpp_entry_st_t;
   fpp_entry_st_t st, nxt;

   always_comb begin
      nxt = st;
      nxt.s1 = {socket_pin, reset_pin_n, board_serial_data, board_serial_clock};
      nxt.s2 = st.s1;
      nxt.clk_prev = st.s2[0];
      nxt.rst_prev = st.s2[2];
      if (!st.s2[2]) begin
         // clock held high during reset never counts an edge
         if (st.s2[0] && !st.clk_prev) begin
            if (st.s2[1]) begin
               nxt.cnt = (st.cnt == ENTRY_EDGES) ? st.cnt : st.cnt + 4'h1;
            end else begin
               nxt.cnt = 4'h0;
            end
         end
      end else begin
         nxt.cnt = 4'h0;
         if (!st.rst_prev && st.cnt == ENTRY_EDGES) begin
            nxt.session = 1'b1;
            nxt.attached = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= nxt;
      end
   end

   assign session_ff = st.session;
   assign attached_ff = st.attached;
   assign socket_ff = st.s2[3];

   a_entry_needs_edges: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(st.session) |-> $past(st.cnt) == ENTRY_EDGES && $past(st.s2[2]) && !$past(st.rst_prev))
      else $error("session entered without full clock sequence");
   a_pins_stay_owned: assert property (@(posedge pclk) disable iff (!presetn)
      st.attached |=> st.attached && st.session)
      else $error("tool pins released to application");
endmodule
`default_nettype wire

// ### rtl/fpp_flash_ctrl.sv
// Purpose: flash program sequencer with mode and protection gating, APB slave
// Assumes: flash array answers each request with a one-cycle flash_done pulse
// Notes: option byte is loaded from opt_nv in the first cycle after reset
`default_nettype none
`timescale 1ns/1ns
module fpp_flash_ctrl import fpp_pkg::*; (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // register bus
   input wire fpp_apb_req_t apb_req,
   output fpp_apb_rsp_t apb_rsp,
   // tool pins
   input wire logic board_serial_clock,
   input wire logic board_serial_data,
   input wire logic reset_pin_n,
   input wire logic socket_pin,
   // flash array
   input wire logic [7:0] opt_nv,
   input wire logic flash_done,
   output fpp_flash_req_t flash_req,
   // system
   output logic system_boot,
   output logic serial_pins_owned,
   output logic ext_read_block
);
   typedef struct packed {
      fpp_lock_t lock;
      logic [2:0] csr;
      logic erase_sel;
      logic [15:0] addr;
      logic [7:0] opt_stage;
      logic [7:0] opt_cur;
      logic loaded;
      logic denied;
      fpp_seq_t seq;
      fpp_flash_req_t req;
      fpp_apb_rsp_t rsp;
      logic rd_block;
   } fpp_st_t;
   fpp_st_t st, nxt;
   logic session, attached, socket_mode;
   fpp_mode_t mode;
   logic [15:0] sec0_base;
   logic in_ee, in_sec0, in_sec1, permit, rd_removal, wr_acc, rd_acc;
   logic [7:0] opt_new;

   // ****************************************************
   // pin side
   // ****************************************************
   fpp_link_entry u_entry (
      .pclk(pclk),
      .presetn(presetn),
      .board_serial_clock(board_serial_clock),
      .board_serial_data(board_serial_data),
      .reset_pin_n(reset_pin_n),
      .socket_pin(socket_pin),
      .session_ff(session),
      .attached_ff(attached),
      .socket_ff(socket_mode)
   );

   // ****************************************************
   // region and permission decode
   // ****************************************************
   always_comb begin
      if (session) begin
         mode = MD_SERIAL;
      end else if (socket_mode) begin
         mode = MD_SOCKET;
      end else begin
         mode = MD_SELF;
      end
      sec0_base = SEC0_BASE[st.opt_cur[OPT_SZ +: 2]];
      in_ee = st.addr >= EE_BASE && st.addr <= EE_END;
      in_sec0 = st.addr >= sec0_base;
      in_sec1 = st.addr >= FLASH_BASE && !in_sec0;
      opt_new = st.opt_stage;
      opt_new[OPT_WE] = st.opt_stage[OPT_WE] | st.opt_cur[OPT_WE];
      rd_removal = st.opt_cur[OPT_RD] && !opt_new[OPT_RD];
      if (st.csr[CSR_OPT]) begin
         permit = mode != MD_SELF;
      end else if (in_ee) begin
         permit = 1'b1;
      end else if (in_sec0) begin
         permit = mode != MD_SELF && !st.opt_cur[OPT_WE];
      end else begin
         permit = in_sec1 && !st.opt_cur[OPT_WE];
      end
      wr_acc = apb_req.psel && apb_req.penable && st.rsp.pready && apb_req.pwrite;
      rd_acc = apb_req.psel && apb_req.penable && st.rsp.pready && !apb_req.pwrite;
   end

   // ****************************************************
   // next state
   // ****************************************************
   always_comb begin
      nxt = st;
      nxt.req.valid = 1'b0;
      nxt.rsp.pready = apb_req.psel && !apb_req.penable;
      if (!st.loaded) begin
         nxt.opt_cur = opt_nv;
         nxt.opt_stage = opt_nv;
         nxt.loaded = 1'b1;
      end
      // read data is prepared in the setup cycle
      if (apb_req.psel && !apb_req.penable) begin
         nxt.rsp.pslverr = 1'b0;
         nxt.rsp.prdata = '0;
         case (apb_req.paddr)
            OFF_CSR: nxt.rsp.prdata[2:0] = st.csr;
            OFF_ADDR: nxt.rsp.prdata[ADDR_ERASE:0] = {st.erase_sel, st.addr};
            OFF_DATA: nxt.rsp.prdata = '0;
            OFF_OPT: nxt.rsp.prdata[7:0] = st.opt_stage;
            OFF_STAT: nxt.rsp.prdata[15:0] = {mode, st.lock, st.seq, st.denied,
                                              attached, st.opt_cur};
            default: nxt.rsp.pslverr = 1'b1;
         endcase
      end
      if (rd_acc && apb_req.paddr == OFF_STAT) begin
         nxt.denied = 1'b0;
      end
      if (wr_acc) begin
         case (apb_req.paddr)
            OFF_CSR: begin
               case (st.lock)
                  LK_LOCKED: begin
                     nxt.lock = (apb_req.pwdata[7:0] == KEY_FIRST) ? LK_HALF : LK_LOCKED;
                  end
                  LK_HALF: begin
                     nxt.lock = (apb_req.pwdata[7:0] == KEY_SECOND) ? LK_OPEN : LK_LOCKED;
                  end
                  LK_OPEN: begin
                     if (apb_req.pwdata[7:3] != 5'h00) begin
                        nxt.lock = LK_LOCKED;
                     end else if (st.seq == SQ_IDLE) begin
                        nxt.csr = apb_req.pwdata[2:0];
                     end
                  end
                  default: nxt.lock = LK_LOCKED;
               endcase
            end
            OFF_ADDR: begin
               nxt.addr = apb_req.pwdata[15:0];
               nxt.erase_sel = apb_req.pwdata[ADDR_ERASE];
            end
            OFF_DATA: begin
               // bytes land in the row latch only while the latch is enabled
               if (st.csr[CSR_LAT] && st.seq == SQ_IDLE) begin
                  nxt.req.data[st.addr[IDX_W-1:0]] = apb_req.pwdata[7:0];
                  nxt.req.mask[st.addr[IDX_W-1:0]] = 1'b1;
               end
            end
            OFF_OPT: nxt.opt_stage = apb_req.pwdata[7:0];
            default: nxt.opt_stage = st.opt_stage;
         endcase
      end
      // dropping the latch enable discards anything latched
      if (st.csr[CSR_LAT] && !nxt.csr[CSR_LAT]) begin
         nxt.req.mask = '0;
      end
      case (st.seq)
         SQ_IDLE: begin
            if (st.csr[CSR_PGM] && st.loaded) begin
               if (!permit) begin
                  nxt.denied = 1'b1;
                  nxt.csr = CSR_RESET;
                  nxt.req.mask = '0;
               end else begin
                  nxt.req.valid = 1'b1;
                  nxt.req.addr = st.addr;
                  nxt.req.opt_row = st.csr[CSR_OPT];
                  nxt.req.erase = st.erase_sel;
                  nxt.req.erase_all = st.csr[CSR_OPT] && rd_removal;
                  nxt.seq = nxt.req.erase_all ? SQ_WAIT_ALL : SQ_WAIT;
                  if (st.csr[CSR_OPT]) begin
                     nxt.req.data[0] = opt_new;
                  end
               end
            end
         end
         SQ_WAIT_ALL: begin
            if (flash_done) begin
               nxt.req.valid = 1'b1;
               nxt.req.erase_all = 1'b0;
               nxt.req.erase = 1'b0;
               nxt.seq = SQ_WAIT;
            end
         end
         SQ_WAIT: begin
            if (flash_done) begin
               if (st.req.opt_row) begin
                  nxt.opt_cur = st.req.data[0];
               end
               nxt.csr = CSR_RESET;
               nxt.req.mask = '0;
               nxt.seq = SQ_IDLE;
            end
         end
         default: nxt.seq = SQ_IDLE;
      endcase
      nxt.rd_block = nxt.opt_cur[OPT_RD] && mode != MD_SELF;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= nxt;
      end
   end

   assign apb_rsp = st.rsp;
   assign flash_req = st.req;
   assign system_boot = session;
   assign serial_pins_owned = attached;
   assign ext_read_block = st.rd_block;

   // ****************************************************
   // checks
   // ****************************************************
   sequence s_prog_start;
      st.seq == SQ_IDLE && st.csr[CSR_PGM] && st.loaded;
   endsequence
   // the option write must come straight after the full erase answers
   sequence s_opt_follows;
      st.req.valid && st.req.opt_row && !st.req.erase_all;
   endsequence

   a_lock_ignores_pgm: assert property (@(posedge pclk) disable iff (!presetn)
      st.lock != LK_OPEN && !st.csr[CSR_PGM] |=> !st.csr[CSR_PGM])
      else $error("program bit set while locked");
   a_self_no_sector0: assert property (@(posedge pclk) disable iff (!presetn)
      st.req.valid && !st.req.erase_all && mode == MD_SELF
      |-> !st.req.opt_row && st.req.addr < sec0_base)
      else $error("sector 0 or option row touched in self programming");
   a_we_guard_flash: assert property (@(posedge pclk) disable iff (!presetn)
      st.req.valid && !st.req.opt_row && !st.req.erase_all && st.opt_cur[OPT_WE]
      |-> st.req.addr >= EE_BASE && st.req.addr <= EE_END)
      else $error("flash request issued under write guard");
   a_we_guard_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      st.loaded && st.opt_cur[OPT_WE] |=> st.opt_cur[OPT_WE])
      else $error("write guard was cleared");
   a_erase_before_opt: assert property (@(posedge pclk) disable iff (!presetn)
      st.req.valid && st.req.opt_row && st.opt_cur[OPT_RD] && !st.req.data[0][OPT_RD]
      && !st.req.erase_all |-> $past(st.seq) == SQ_WAIT_ALL)
      else $error("guard removed without full erase");
   a_erase_all_then_opt: assert property (@(posedge pclk) disable iff (!presetn)
      st.seq == SQ_WAIT_ALL && flash_done |=> s_opt_follows)
      else $error("option write did not follow erase");
   a_denied_drop: assert property (@(posedge pclk) disable iff (!presetn)
      s_prog_start and !permit |=> !st.req.valid && st.denied && st.csr == CSR_RESET)
      else $error("forbidden request not dropped");
   a_done_clears: assert property (@(posedge pclk) disable iff (!presetn)
      st.seq == SQ_WAIT && flash_done |=> st.csr == CSR_RESET && st.req.mask == '0
      ##1 st.seq == SQ_IDLE)
      else $error("control bits not cleared at end of cycle");
   a_rd_block: assert property (@(posedge pclk) disable iff (!presetn)
      st.loaded && $past(st.loaded) && mode == MD_SERIAL && $stable(session)
      && st.opt_cur[OPT_RD] && $stable(st.opt_cur) |-> st.rd_block)
      else $error("extraction not blocked under read guard");
   // a wrong second key must fall all the way back, not stay half open
   a_lock_relock: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && apb_req.paddr == OFF_CSR && st.lock == LK_HALF
      && apb_req.pwdata[7:0] != KEY_SECOND |=> st.lock == LK_LOCKED)
      else $error("wrong second key left the register unlocked");
   a_denied_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      st.denied && !(rd_acc && apb_req.paddr == OFF_STAT) |=> st.denied)
      else $error("denied flag lost before status read");
   a_latch_discard: assert property (@(posedge pclk) disable iff (!presetn)
      st.csr[CSR_LAT] && !nxt.csr[CSR_LAT] |=> st.req.mask == '0)
      else $error("latched bytes survived latch disable");
   a_req_addr_kept: assert property (@(posedge pclk) disable iff (!presetn)
      st.req.valid && !st.req.opt_row |-> st.req.addr == $past(st.addr))
      else $error("request address differs from the selected row");
   a_opt_row_mode: assert property (@(posedge pclk) disable iff (!presetn)
      st.req.valid && st.req.opt_row |-> mode != MD_SELF)
      else $error("option row written in self programming");
endmodule
`default_nettype wire

// ### bench/fpp_tool_model.sv
// Purpose: behavioural programming tool on the two-wire link and the reset pin
// Assumes: link pins are asynchronous to pclk, link period 125 ns
// Notes: the data line has no pull-up, so it wanders while released
`timescale 1ns/1ns
`default_nettype none
module fpp_tool_model (
   // tool pins
   output logic board_serial_clock,
   output logic board_serial_data,
   output logic reset_pin_n
);
   logic framed;
   initial begin
      board_serial_clock = 1'b1;
      board_serial_data = 1'b0;
      reset_pin_n = 1'b1;
      framed = 1'b0;
   end
   // a stale level must never look like a driven one
   always #37 if (!framed) board_serial_data = ~board_serial_data;
   // ****************************************************
   // entry sequence, clock idles high outside it
   // ****************************************************
   task automatic enter(input int edges);
      framed = 1'b1;
      board_serial_data = 1'b1;
      reset_pin_n = 1'b0;
      #125;
      repeat (edges) begin
         board_serial_clock = 1'b0;
         #62;
         board_serial_clock = 1'b1;
         #63;
      end
      #125;
      reset_pin_n = 1'b1;
      framed = 1'b0;
      #250;
   endtask
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Purpose: self-checking bench of the flash program and protect block
// Assumes: flash array answers each request one cycle later
// Notes: option byte is latched at reset, so each option set gets a reset
`timescale 1ns/1ns
`default_nettype none
module tb_top import fpp_pkg::*;;
   logic pclk, presetn, socket_pin, flash_done, bclk, bdata, rpin_n;
   logic system_boot, pins_owned, read_block;
   logic [7:0] opt_nv;
   fpp_apb_req_t req;
   fpp_apb_rsp_t rsp;
   fpp_flash_req_t flash_req;
   fpp_flash_req_t reqs[$];
   int bad_count, compares, cyc;
   fpp_flash_ctrl DUT (
      .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
      .board_serial_clock(bclk), .board_serial_data(bdata), .reset_pin_n(rpin_n),
      .socket_pin(socket_pin), .opt_nv(opt_nv), .flash_done(flash_done),
      .flash_req(flash_req), .system_boot(system_boot), .serial_pins_owned(pins_owned),
      .ext_read_block(read_block));
   fpp_tool_model tool (.board_serial_clock(bclk), .board_serial_data(bdata),
      .reset_pin_n(rpin_n));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // ****************************************************
   // flash array stand-in and hang guard
   // ****************************************************
   always @(posedge pclk) begin
      flash_done <= flash_req.valid;
      if (flash_req.valid === 1'b1) reqs.push_back(flash_req);
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         close_out();
      end
   end
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // ****************************************************
   // bus cycles
   // ****************************************************
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      // only the cycle ceiling ends a wait for pready
      do begin
         @(posedge pclk);
      end while (rsp.pready !== 1'b1);
      r = rsp.prdata;
      e = rsp.pslverr;
      req <= '0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] r;
      rd(a, r);
      chk(r & m, exp);
   endtask
   task automatic unlock();
      wr(OFF_CSR, {24'h0, KEY_FIRST});
      wr(OFF_CSR, {24'h0, KEY_SECOND});
   endtask
   // start a sequence and wait for the control register to fall back
   task automatic run(input logic [7:0] c);
      logic [31:0] r;
      reqs.delete();
      wr(OFF_CSR, {24'h0, c});
      do begin
         rd(OFF_CSR, r);
      end while (r[0] !== 1'b0);
      chk(r, 32'h0);
   endtask
   task automatic prog(input logic [15:0] a, input logic [7:0] d, input logic ok);
      wr(OFF_CSR, 32'h2);
      wr(OFF_ADDR, {16'h0, a});
      wr(OFF_DATA, {24'h0, d});
      run(8'h3);
      chk(32'(reqs.size()), {31'h0, ok});
      if (ok) begin
         chk({16'h0, reqs[0].addr}, {16'h0, a});
         chk({24'h0, reqs[0].data[a[4:0]]}, {24'h0, d});
         chk(reqs[0].mask, 32'h1 << a[4:0]);
      end
      rdc(OFF_STAT, 32'h200, {22'h0, !ok, 9'h0});
   endtask
   task automatic do_reset(input logic [7:0] o, input logic s);
      @(posedge pclk);
      presetn <= 1'b0;
      opt_nv <= o;
      socket_pin <= s;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask
   // ****************************************************
   // scenarios
   // ****************************************************
   initial begin
      logic [31:0] r;
      logic e;
      req = '0;
      presetn = 1'b0;
      socket_pin = 1'b0;
      flash_done = 1'b0;
      opt_nv = 8'h00;
      bad_count = 0;
      compares = 0;
      cyc = 0;
      do_reset(8'h00, 1'b0);
      rdc(OFF_STAT, 32'hffff, 32'h0);
      wr(OFF_CSR, 32'h7);
      rdc(OFF_CSR, 32'hff, 32'h0);
      wr(OFF_CSR, {24'h0, KEY_SECOND});
      wr(OFF_CSR, {24'h0, KEY_FIRST});
      rdc(OFF_STAT, 32'h3000, 32'h1000);
      wr(OFF_CSR, {24'h0, KEY_SECOND});
      rdc(OFF_STAT, 32'h3000, 32'h2000);
      wr(OFF_CSR, 32'h2);
      rdc(OFF_CSR, 32'hff, 32'h2);
      wr(OFF_CSR, 32'h80);
      rdc(OFF_STAT, 32'h3000, 32'h0);
      unlock();
      prog(16'hf000, 8'h5a, 1'b1);
      prog(16'hfdff, 8'ha5, 1'b1);
      prog(16'hfe00, 8'h3c, 1'b0);
      prog(16'h107f, 8'hc3, 1'b1);
      prog(16'h2000, 8'h11, 1'b0);
      wr(OFF_OPT, 32'h0);
      run(8'h5);
      chk(32'(reqs.size()), 32'h0);
      apb(1'b0, 8'h40, 32'h0, r, e);
      chk({r[30:0], e}, 32'h1);
      chk({31'h0, read_block}, 32'h0);
      // socket, both guards set
      do_reset(8'h03, 1'b1);
      rdc(OFF_STAT, 32'hffff, 32'h4003);
      chk({31'h0, read_block}, 32'h1);
      unlock();
      prog(16'hf000, 8'h5a, 1'b0);
      prog(16'h1000, 8'h77, 1'b1);
      wr(OFF_OPT, 32'h0);
      run(8'h5);
      chk(32'(reqs.size()), 32'h2);
      chk({30'h0, reqs[0].erase_all, reqs[1].opt_row}, 32'h3);
      chk({24'h0, reqs[1].data[0]}, 32'h2);
      // serial session
      do_reset(8'h00, 1'b0);
      tool.enter(3);
      chk({31'h0, system_boot}, 32'h0);
      tool.enter(4);
      chk({30'h0, system_boot, pins_owned}, 32'h3);
      rdc(OFF_STAT, 32'hc100, 32'h8100);
      unlock();
      prog(16'hfe00, 8'h3c, 1'b1);
      wr(OFF_ADDR, 32'h1fe00);
      run(8'h1);
      chk({30'h0, reqs[0].erase, reqs[0].erase_all}, 32'h2);
      chk({16'h0, reqs[0].addr}, 32'hfe00);
      // larger sector 0
      do_reset(8'h04, 1'b0);
      unlock();
      prog(16'hfc00, 8'h12, 1'b0);
      prog(16'hfbff, 8'h34, 1'b1);
      close_out();
   end
endmodule
`default_nettype wire
